// ===== ptw_pkg.sv
package ptw_pkg;

  // ------------------------------------------------------------
  // Widths and command codes
  // ------------------------------------------------------------
  localparam int         ADDR_W       = 32;
  localparam int         DATA_W       = 32;
  localparam int         BE_W         = 4;
  localparam int         NUM_WIN      = 2;
  localparam logic [3:0] CMD_MEM_WR   = 4'h7;
  localparam logic [3:0] CMD_MEM_RD   = 4'h6;

  // ------------------------------------------------------------
  // Window defaults
  // ------------------------------------------------------------
  localparam logic [31:0] WIN0_BASE   = 32'h1000_0000;
  localparam logic [31:0] WIN1_BASE   = 32'h2000_0000;
  localparam logic [31:0] WIN_MASK    = 32'hFFFF_0000;

  // ------------------------------------------------------------
  // Select response speed
  // ------------------------------------------------------------
  localparam logic        SPEED_SLOW  = 1'b1;

endpackage : ptw_pkg

// ===== ptw_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ptw_bus_if;
  // Shared PCI lines: each end drives its own value with an enable
  logic [31:0] ad_m;
  logic        ad_m_oe;
  logic [3:0]  cben_m;
  logic        cben_m_oe;
  logic        framen_m;
  logic        framen_m_oe;
  logic        irdyn_m;
  logic        irdyn_m_oe;
  logic        devseln_t;
  logic        devseln_t_oe;
  logic        trdyn_t;
  logic        trdyn_t_oe;
  // Resolved levels, worked out by the testbench from the enables
  logic [31:0] ad;
  logic [3:0]  cben;
  logic        framen;
  logic        irdyn;
  logic        devseln;
  logic        trdyn;

  modport master (
    output ad_m, ad_m_oe, cben_m, cben_m_oe, framen_m, framen_m_oe,
    output irdyn_m, irdyn_m_oe,
    input  ad, cben, framen, irdyn, devseln, trdyn
  );
  modport target (
    output devseln_t, devseln_t_oe, trdyn_t, trdyn_t_oe,
    input  ad, cben, framen, irdyn, devseln, trdyn
  );
endinterface : ptw_bus_if
`default_nettype wire

// ===== ptw_win_dec.sv
`timescale 1ns/1ps
`default_nettype none
module ptw_win_dec #(
  parameter int          NUM_WIN = ptw_pkg::NUM_WIN,
  parameter logic [31:0] MASK    = ptw_pkg::WIN_MASK,
  parameter logic [63:0] BASES   = {ptw_pkg::WIN1_BASE, ptw_pkg::WIN0_BASE}
) (
  input  wire logic [31:0]        addr,
  output wire logic [NUM_WIN-1:0] hit
);
  initial begin
    if (NUM_WIN < 1 || NUM_WIN > 2) $error("NUM_WIN must be 1 or 2");
  end

  // ------------------------------------------------------------
  // One comparator per window
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_win
      assign hit[g] = ((addr & MASK) == (BASES[g*32 +: 32] & MASK));
    end
  endgenerate
endmodule : ptw_win_dec
`default_nettype wire

// ===== ptw_target.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Master gives byte enables, irdyn, first data
// - Clock two: decode, show local address
// - Clock three: window select on match
// - Slow speed: devseln one clock after select
// - Back-end readies one cycle ahead of trdyn
// - trdyn follows ready of previous cycle
// - Held ready keeps trdyn, shows previous word
// - Master keeps irdyn, drives next word
// - irdyn and ready last cycle give strobe
// - Back-end commits only under strobe
// - Master drops framen on last word
// - Turnaround shows final word when ready held
// - Master releases bus after final phase
// - Last phase done: drop devseln and trdyn
// - Clear select, strobe; release next idle clock
module ptw_target #(
  parameter int NUM_WIN = ptw_pkg::NUM_WIN
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  ptw_bus_if.target                      bus,
  input  wire logic                      select_response_speed,
  input  wire logic                      backend_ready_n,
  output logic      [ptw_pkg::ADDR_W-1:0] local_target_addr,
  output logic      [NUM_WIN-1:0]         win_sel,
  output logic      [ptw_pkg::DATA_W-1:0] local_wr_data,
  output logic      [ptw_pkg::BE_W-1:0]   local_wr_be,
  output logic                            local_xfer_done_n
);
  initial begin
    if (NUM_WIN < 1 || NUM_WIN > 2) $error("NUM_WIN must be 1 or 2");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_DECODE = 6'b000010,
    ST_CLAIM  = 6'b001000,
    ST_DATA   = 6'b010000,
    ST_TURN   = 6'b100000
  } ptw_tstate_t;

  typedef struct packed {
    ptw_tstate_t                st;
    logic [ptw_pkg::ADDR_W-1:0] addr;
    logic [3:0]                 cmd;
    logic [NUM_WIN-1:0]         sel;
    logic                       devsel;
    logic                       trdy;
    logic                       drive;
    logic                       rdy_q;
    logic                       irdy_q;
    logic                       last_q;
    logic [ptw_pkg::DATA_W-1:0] wdata;
    logic [ptw_pkg::BE_W-1:0]   wbe;
    logic                       xfer;
  } ptw_tgt_t;

  ptw_tgt_t           s_reg;
  ptw_tgt_t           s_next;
  logic [NUM_WIN-1:0] hit;

  ptw_win_dec #(.NUM_WIN(NUM_WIN)) u_dec (
    .addr (s_reg.addr),
    .hit  (hit)
  );

  function automatic logic is_write(input logic [3:0] c);
    is_write = (c == ptw_pkg::CMD_MEM_WR);
  endfunction : is_write

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic rdy;
    logic irdy;
    logic done;
    rdy    = !backend_ready_n;
    irdy   = !bus.irdyn;
    done   = irdy && s_reg.trdy;
    s_next = s_reg;
    s_next.rdy_q  = rdy;
    s_next.irdy_q = irdy;
    s_next.xfer   = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.drive = 1'b0;
        if (!bus.framen) begin
          s_next.addr = bus.ad;
          s_next.cmd  = bus.cben;
          s_next.st   = ST_DECODE;
        end
      end
      ST_DECODE: begin
        // Address already on local_target_addr; select lands in clock three
        if (is_write(s_reg.cmd) && (hit != '0)) begin
          s_next.sel = hit;
          s_next.st  = ST_CLAIM;
        end else begin
          // Ignore transaction until the bus goes idle
          s_next.st = ST_TURN;
        end
      end
      ST_CLAIM: begin
        s_next.devsel = 1'b1;
        s_next.drive  = 1'b1;
        s_next.st     = ST_DATA;
        if (select_response_speed != ptw_pkg::SPEED_SLOW) begin
          s_next.devsel = 1'b1;
        end
      end
      ST_DATA: begin
        s_next.trdy = rdy;
        if (done) begin
          // Word taken from the bus in this phase
          s_next.wdata  = bus.ad;
          s_next.wbe    = bus.cben;
          s_next.last_q = bus.framen;
        end
        // Strobe only with a captured word, never on a stale one
        if (done) begin
          s_next.xfer = 1'b1;
        end
        if (done && bus.framen) begin
          s_next.devsel = 1'b0;
          s_next.trdy   = 1'b0;
          s_next.st     = ST_TURN;
        end
      end
      ST_TURN: begin
        // Final word was strobed on entry; a second strobe would repeat it
        s_next.xfer  = 1'b0;
        s_next.sel   = '0;
        s_next.drive = 1'b0;
        if (bus.framen && bus.irdyn) begin
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '{st: ST_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign local_target_addr = s_reg.addr;
  assign win_sel           = s_reg.sel;
  assign local_wr_data     = s_reg.wdata;
  assign local_wr_be       = s_reg.wbe;
  assign local_xfer_done_n = !s_reg.xfer;
  // Driven high for one clock after release, then floated
  assign bus.devseln_t     = !s_reg.devsel;
  assign bus.devseln_t_oe  = s_reg.drive;
  assign bus.trdyn_t       = !s_reg.trdy;
  assign bus.trdyn_t_oe    = s_reg.drive;
endmodule : ptw_target
`default_nettype wire

// ===== ptw_master.sv
`timescale 1ns/1ps
`default_nettype none
module ptw_master #(
  parameter int MAX_LEN = 16
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  ptw_bus_if.master        bus,
  input  wire logic        start,
  input  wire logic [31:0] start_addr,
  input  wire logic [4:0]  burst_len,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_be,
  output logic             data_take,
  output logic             busy
);
  initial begin
    if (MAX_LEN < 1 || MAX_LEN > 31) $error("MAX_LEN must be 1..31");
  end

  // Count of clocks without device select; the master gives up on the next such clock
  localparam logic [2:0] ABORT_WAIT = 3'h5;

  typedef enum logic [3:0] {
    SM_IDLE = 4'b0001,
    SM_ADDR = 4'b0010,
    SM_DATA = 4'b0100,
    SM_TURN = 4'b1000
  } ptw_mstate_t;

  typedef struct packed {
    ptw_mstate_t st;
    logic [4:0]  left;
    logic [31:0] ad;
    logic [3:0]  be;
    logic        frame;
    logic        irdy;
    logic        drv;
    logic [2:0]  wait_cnt;
  } ptw_mst_t;

  ptw_mst_t s_reg;
  ptw_mst_t s_next;
  logic     done;

  // Word accepted by target in this clock
  assign done      = s_reg.irdy && !bus.trdyn;
  assign data_take = (s_reg.st == SM_ADDR) || (done && s_reg.left > 5'h01);
  assign busy      = (s_reg.st != SM_IDLE);

  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      SM_IDLE: begin
        if (start && burst_len != 5'h00) begin
          s_next.ad    = start_addr;
          s_next.be    = ptw_pkg::CMD_MEM_WR;
          s_next.frame = 1'b1;
          s_next.drv   = 1'b1;
          s_next.left  = burst_len;
          s_next.wait_cnt = 3'h0;
          s_next.st    = SM_ADDR;
        end
      end
      SM_ADDR: begin
        s_next.ad   = wr_data;
        s_next.be   = wr_be;
        s_next.irdy = 1'b1;
        s_next.frame = (s_reg.left != 5'h01);
        s_next.st   = SM_DATA;
      end
      SM_DATA: begin
        if (done) begin
          s_next.left = s_reg.left - 5'h01;
          if (s_reg.left == 5'h01) begin
            s_next.irdy = 1'b0;
            s_next.st   = SM_TURN;
          end else begin
            s_next.ad    = wr_data;
            s_next.be    = wr_be;
            s_next.frame = (s_reg.left != 5'h02);
          end
        end else if (bus.devseln) begin
          // No target claimed the address: end the burst instead of hanging
          s_next.wait_cnt = s_reg.wait_cnt + 3'h1;
          if (s_reg.wait_cnt == ABORT_WAIT) begin
            s_next.frame = 1'b0;
            s_next.irdy  = 1'b0;
            s_next.st    = SM_TURN;
          end
        end
      end
      SM_TURN: begin
        s_next.drv = 1'b0;
        s_next.st  = SM_IDLE;
      end
      default: begin
        s_next.st = SM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '{st: SM_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.ad_m        = s_reg.ad;
  assign bus.ad_m_oe     = s_reg.drv && (s_reg.st != SM_TURN);
  assign bus.cben_m      = s_reg.be;
  assign bus.cben_m_oe   = s_reg.drv && (s_reg.st != SM_TURN);
  assign bus.framen_m    = !s_reg.frame;
  assign bus.framen_m_oe = s_reg.drv;
  assign bus.irdyn_m     = !s_reg.irdy;
  assign bus.irdyn_m_oe  = s_reg.drv;
endmodule : ptw_master
`default_nettype wire

// ===== ptw_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ptw_asserts (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic [31:0]               ad,
  input wire logic [3:0]                cben,
  input wire logic                      framen,
  input wire logic                      irdyn,
  input wire logic                      devseln,
  input wire logic                      devseln_t_oe,
  input wire logic                      trdyn,
  input wire logic                      backend_ready_n,
  input wire logic [31:0]               local_target_addr,
  input wire logic [ptw_pkg::NUM_WIN-1:0] win_sel,
  input wire logic [31:0]               local_wr_data,
  input wire logic                      local_xfer_done_n
);
  // ------------------------------------------------------------
  // Transaction steps
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_hit0;
    $fell(framen) && cben == ptw_pkg::CMD_MEM_WR && ad[31:16] == 16'h1000;
  endsequence
  sequence s_miss;
    $fell(framen) && ad[31:16] != 16'h1000 && ad[31:16] != 16'h2000;
  endsequence
  // Last data phase: framen already high while both readies low
  sequence s_last;
    !irdyn && !trdyn && framen;
  endsequence
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_addr_shown: assert property ($fell(framen) |=> local_target_addr == $past(ad))
    else $error("local address not captured");
  a_select_win0: assert property (s_hit0 |-> ##2 win_sel == 2'h1 ##1 !devseln)
    else $error("window select or device select late");
  a_devsel_slow: assert property ($rose(|win_sel) |=> !devseln)
    else $error("device select not one clock after select");
  a_trdy_follow: assert property ($fell(trdyn) |-> $past(backend_ready_n) == 1'b0)
    else $error("target ready without back-end ready");
  a_trdy_hold: assert property (!trdyn && !framen && !backend_ready_n |=> !trdyn)
    else $error("target ready dropped mid burst");
  a_strobe_given: assert property (!irdyn && !trdyn && !backend_ready_n
    |=> !local_xfer_done_n && local_wr_data == $past(ad))
    else $error("word not strobed to back-end");
  a_strobe_cause: assert property (!local_xfer_done_n
    |-> $past(irdyn) == 1'b0 && $past(backend_ready_n) == 1'b0)
    else $error("strobe without cause");
  a_last_release: assert property (s_last
    |=> (devseln && trdyn) ##1 (win_sel == 2'h0 && !devseln_t_oe))
    else $error("completion not signalled");
  a_no_match: assert property (s_miss |=> (devseln && win_sel == 2'h0) [*6])
    else $error("response to unmatched address");
endmodule : ptw_asserts
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------
  logic        clk;
  logic        nrst;
  logic        start;
  logic [31:0] start_addr;
  logic [4:0]  burst_len;
  logic        data_take;
  logic        busy;
  logic        backend_ready_n;
  logic [31:0] local_target_addr;
  logic [1:0]  win_sel;
  logic [1:0]  sel_seen;
  logic [31:0] local_wr_data;
  logic [3:0]  local_wr_be;
  logic        local_xfer_done_n;
  logic [35:0] next_word;
  int          idx, got, cyc, ready_delay, fail_count, comparisons;
  ptw_bus_if bus ();
  // Released lines float to their pull-up level
  assign bus.ad      = bus.ad_m_oe ? bus.ad_m : 32'hFFFF_FFFF;
  assign bus.cben    = bus.cben_m_oe ? bus.cben_m : 4'hF;
  assign bus.framen  = bus.framen_m_oe ? bus.framen_m : 1'b1;
  assign bus.irdyn   = bus.irdyn_m_oe ? bus.irdyn_m : 1'b1;
  assign bus.devseln = bus.devseln_t_oe ? bus.devseln_t : 1'b1;
  assign bus.trdyn   = bus.trdyn_t_oe ? bus.trdyn_t : 1'b1;
  function automatic logic [35:0] pat(input int i);
    pat = {4'h1 | i[3:0], 32'hA5A5_0000 + i};
  endfunction : pat
  assign next_word = pat(idx);
  ptw_master ptw_master_i (.clk(clk), .nrst(nrst), .bus(bus), .start(start),
    .start_addr(start_addr), .burst_len(burst_len), .wr_data(next_word[31:0]),
    .wr_be(next_word[35:32]), .data_take(data_take), .busy(busy));
  ptw_target ptw_target_i (.clk(clk), .nrst(nrst), .bus(bus),
    .select_response_speed(ptw_pkg::SPEED_SLOW), .backend_ready_n(backend_ready_n),
    .local_target_addr(local_target_addr), .win_sel(win_sel), .local_wr_data(local_wr_data),
    .local_wr_be(local_wr_be), .local_xfer_done_n(local_xfer_done_n));
  ptw_asserts ptw_asserts_i (.clk(clk), .nrst(nrst), .ad(bus.ad), .cben(bus.cben),
    .framen(bus.framen), .irdyn(bus.irdyn), .devseln(bus.devseln),
    .devseln_t_oe(bus.devseln_t_oe), .trdyn(bus.trdyn), .backend_ready_n(backend_ready_n),
    .local_target_addr(local_target_addr), .win_sel(win_sel), .local_wr_data(local_wr_data),
    .local_xfer_done_n(local_xfer_done_n));
  // ------------------------------------------------------------
  // Clock, back-end and checks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (data_take === 1'b1) #1 idx = idx + 1;
  end
  task automatic check(input logic [35:0] act, input logic [35:0] exp);
    comparisons++;
    if (act !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h, expected %h", $time, act, exp);
    end
  endtask : check
  // Back-end commits only strobed words; ready may come late
  always @(posedge clk) begin
    cyc = (|win_sel) ? cyc + 1 : 0;
    sel_seen = sel_seen | win_sel;
    if (local_xfer_done_n === 1'b0) begin
      check({local_wr_be, local_wr_data}, pat(got));
      got = got + 1;
    end
    #1 backend_ready_n = !(|win_sel) || cyc <= ready_delay;
  end
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic burst(input logic [31:0] a, input logic [4:0] n, input int exp,
                       input logic [1:0] sel);
    int k;
    got = 0;
    idx = 0;
    sel_seen = 2'h0;
    start_addr = a;
    burst_len = n;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk) #1;
    if (k == 100) begin
      fail_count++;
      wrap_up();
    end
    repeat (4) @(posedge clk);
    #1 check(36'(got), 36'(exp));
    check(36'(sel_seen), 36'(sel));
    check(36'(local_target_addr), 36'(a));
  endtask : burst
  initial begin
    nrst = 1'b0;
    start = 1'b0;
    start_addr = 32'h0;
    burst_len = 5'h1;
    backend_ready_n = 1'b1;
    {idx, got, cyc, ready_delay, fail_count, comparisons} = '0;
    sel_seen = 2'h0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    burst(32'h1000_0010, 5'h3, 3, 2'h1);
    burst(32'h2000_FFFC, 5'h1, 1, 2'h2);
    ready_delay = 3;
    burst(32'h1000_0100, 5'h1F, 31, 2'h1);
    ready_delay = 0;
    burst(32'h3000_0000, 5'h2, 0, 2'h0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
